// ==== hw/plc_defines.svh ====
// plc_defines.svh: command codes, reset words, limits, encodings
// Assumes inclusion by plc_pkg and the command set core only
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// ----------------------------------------------------------
// Command codes
// ----------------------------------------------------------
`define PLC_CMD_RUN      8'h01
`define PLC_CMD_ONOFF    8'h02
`define PLC_CMD_CLR      8'h03
`define PLC_CMD_WG       8'h10
`define PLC_CMD_STORE    8'h11
`define PLC_CMD_RESTORE  8'h12
`define PLC_CMD_MODE     8'h20
`define PLC_CMD_VSET     8'h21
`define PLC_CMD_VIN_ON   8'h35
`define PLC_CMD_VIN_OFF  8'h36
`define PLC_CMD_OV_TRIP  8'h40
`define PLC_CMD_OV_ALERT 8'h42
`define PLC_CMD_OC_TRIP  8'h46
`define PLC_CMD_OC_ALERT 8'h4a
`define PLC_CMD_OT_TRIP  8'h4f
`define PLC_CMD_UNLOCK   8'hec

// ----------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------
`define PLC_RST_RUN      8'h80
`define PLC_ONOFF_NEG    8'h1d
`define PLC_ONOFF_POS    8'h1f
`define PLC_WG_ALL       8'h80
`define PLC_WG_OPS       8'h40
`define PLC_WG_CFG       8'h20
`define PLC_WG_NONE      8'h00
`define PLC_MODE_VAL     8'h14
`define PLC_EXP_VIN      5'h1d
`define PLC_EXP_IOUT     5'h1d
`define PLC_EXP_TEMP     5'h1e
`define PLC_RST_VSET     16'hc333
`define PLC_RST_VIN_ON   16'he93c
`define PLC_RST_VIN_OFF  16'he930
`define PLC_RST_OV_TRIP  16'hd800
`define PLC_RST_OV_ALERT 16'hd000
`define PLC_RST_OC_TRIP  16'he9e0
`define PLC_RST_OC_ALERT 16'he9b8
`define PLC_RST_OT_TRIP  16'hf21c
`define PLC_OT_WARN      16'hf190

// ----------------------------------------------------------
// Allowed ranges
// ----------------------------------------------------------
`define PLC_OVA_MIN      16'hc800
`define PLC_OVA_MAX      16'hd800
`define PLC_OCA_MIN      16'he968
`define PLC_OCA_MAX      16'he9b8
`define PLC_OT_MIN       16'hf190
`define PLC_OT_MAX       16'hf21c
`define PLC_RD_NONE      16'hffff

`endif

// ==== hw/plc_pkg.sv ====
// plc_pkg: parameter store, fault and state types, word helpers
// Assumes plc_defines.svh on the include path
package plc_pkg;
`include "plc_defines.svh"

  typedef struct packed {
    logic [7:0] run_ctl;
    logic [7:0] onoff_cfg;
    logic [7:0] wguard;
    logic [15:0] vout_set;
    logic [15:0] vin_on;
    logic [15:0] vin_off;
    logic [15:0] ov_trip;
    logic [15:0] ov_alert;
    logic [15:0] oc_trip;
    logic [15:0] oc_alert;
    logic [15:0] ot_trip;
  } plc_cfg_t;

  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic over_temp;
    logic vin_uv;
  } plc_evt_t;

  typedef struct packed {
    logic cml;
    plc_evt_t pwr;
  } plc_fault_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RXB, ST_ACK, ST_TXB, ST_MACK
  } plc_st_t;

  localparam plc_cfg_t PLC_CFG_RST = '{
    run_ctl: `PLC_RST_RUN, onoff_cfg: `PLC_ONOFF_NEG,
    wguard: `PLC_WG_ALL, vout_set: `PLC_RST_VSET,
    vin_on: `PLC_RST_VIN_ON, vin_off: `PLC_RST_VIN_OFF,
    ov_trip: `PLC_RST_OV_TRIP, ov_alert: `PLC_RST_OV_ALERT,
    oc_trip: `PLC_RST_OC_TRIP, oc_alert: `PLC_RST_OC_ALERT,
    ot_trip: `PLC_RST_OT_TRIP};

  function automatic logic [4:0] plc_lin_exp(input logic [15:0] w);
    return w[15:11];
  endfunction

  function automatic logic [10:0] plc_lin_man(input logic [15:0] w);
    return w[10:0];
  endfunction

  // Read data for a command; unknown and write-only read all ones
  function automatic logic [15:0] plc_read_sel(input logic [7:0] c,
                                               input plc_cfg_t g);
    case (c)
      `PLC_CMD_RUN: return {8'h00, g.run_ctl};
      `PLC_CMD_ONOFF: return {8'h00, g.onoff_cfg};
      `PLC_CMD_WG: return {8'h00, g.wguard};
      `PLC_CMD_MODE: return {8'h00, `PLC_MODE_VAL};
      `PLC_CMD_VSET: return g.vout_set;
      `PLC_CMD_VIN_ON: return g.vin_on;
      `PLC_CMD_VIN_OFF: return g.vin_off;
      `PLC_CMD_OV_TRIP: return g.ov_trip;
      `PLC_CMD_OV_ALERT: return g.ov_alert;
      `PLC_CMD_OC_TRIP: return g.oc_trip;
      `PLC_CMD_OC_ALERT: return g.oc_alert;
      `PLC_CMD_OT_TRIP: return g.ot_trip;
      default: return `PLC_RD_NONE;
    endcase
  endfunction
endpackage

// ==== hw/plc_sync.sv ====
// plc_sync: two-flop synchroniser for a group of pin levels
// Assumes inputs asynchronous to mclk
`timescale 1ns/10ps
module plc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ==== hw/plc_command_set.sv ====
// plc_command_set: SMBus slave front end and linear-format command store
// Assumes scl/sda from the board bus, power-stage events on mclk
`timescale 1ns/10ps
`include "plc_defines.svh"
module plc_command_set #(
  parameter logic [6:0] SLV_ADDR = 7'h2a
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic stage_run,
  input plc_pkg::plc_evt_t fault_evt,
  output plc_pkg::plc_cfg_t cfg,
  output plc_pkg::plc_fault_t faults
);

  // --------------------------------------------------------
  // Pin synchronisation and bus conditions
  // --------------------------------------------------------
  logic scl_s, sda_s, run_s;
  logic scl_d_ff, sda_d_ff;
  plc_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({scl_i, sda_i, stage_run}),
    .q({scl_s, sda_s, run_s})
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire scl_hi = scl_s & scl_d_ff;
  wire start_det = scl_hi & sda_d_ff & ~sda_s;
  wire stop_det = scl_hi & ~sda_d_ff & sda_s;

  // --------------------------------------------------------
  // Byte engine state
  // --------------------------------------------------------
  plc_pkg::plc_st_t st_ff, nxt_st;
  logic [3:0] bit_cnt_ff, nxt_bit;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff, nxt_tx;
  logic [2:0] byte_cnt_ff;
  logic rd_ff, nack_ff, tx_hi_ff;
  logic sda_oe_ff, nxt_oe, sda_o_ff;
  logic [7:0] cmd_ff, d0_ff, d1_ff;
  logic unlock_ff;
  plc_pkg::plc_cfg_t cfg_ff, flash_ff;
  plc_pkg::plc_fault_t fault_ff;
  wire byte_done = scl_fall & (st_ff == plc_pkg::ST_RXB) &
                   (bit_cnt_ff == 4'h8);
  wire addr_hit = (rx_sh_ff[7:1] == SLV_ADDR);
  wire ack_ok = (byte_cnt_ff != 3'h0) | addr_hit;
  wire byte_take = byte_done & ack_ok;
  wire [15:0] rd_val = plc_pkg::plc_read_sel(cmd_ff, cfg_ff);
  wire [7:0] rd_byte = tx_hi_ff ? rd_val[15:8] : rd_val[7:0];

  always_comb begin
    nxt_st = st_ff;
    nxt_oe = sda_oe_ff;
    nxt_bit = bit_cnt_ff;
    nxt_tx = tx_sh_ff;
    case (st_ff)
      plc_pkg::ST_IDLE: nxt_oe = 1'b0;
      plc_pkg::ST_RXB: begin
        if (scl_rise) begin
          nxt_bit = bit_cnt_ff + 4'h1;
        end else if (byte_done) begin
          if (ack_ok) begin
            nxt_st = plc_pkg::ST_ACK;
            nxt_oe = 1'b1;
          end else begin
            nxt_st = plc_pkg::ST_IDLE;
          end
        end
      end
      plc_pkg::ST_ACK: begin
        if (scl_fall) begin
          nxt_bit = 4'h0;
          if (rd_ff) begin
            nxt_st = plc_pkg::ST_TXB;
            nxt_tx = rd_byte;
            nxt_oe = ~rd_byte[7];
          end else begin
            nxt_st = plc_pkg::ST_RXB;
            nxt_oe = 1'b0;
          end
        end
      end
      plc_pkg::ST_TXB: begin
        if (scl_fall) begin
          if (bit_cnt_ff == 4'h7) begin
            nxt_st = plc_pkg::ST_MACK;
            nxt_oe = 1'b0;
            nxt_bit = 4'h0;
          end else begin
            nxt_bit = bit_cnt_ff + 4'h1;
            nxt_tx = {tx_sh_ff[6:0], 1'b0};
            nxt_oe = ~tx_sh_ff[6];
          end
        end
      end
      plc_pkg::ST_MACK: begin
        if (scl_fall) begin
          if (nack_ff) begin
            nxt_st = plc_pkg::ST_IDLE;
          end else begin
            nxt_st = plc_pkg::ST_TXB;
            nxt_tx = rd_val[15:8];
            nxt_oe = ~rd_val[15];
          end
        end
      end
      default: begin
        nxt_st = plc_pkg::ST_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
    if (start_det) begin
      nxt_st = plc_pkg::ST_RXB;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
    end
    if (stop_det) begin
      nxt_st = plc_pkg::ST_IDLE;
      nxt_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= plc_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      bit_cnt_ff <= nxt_bit;
      tx_sh_ff <= nxt_tx;
      sda_oe_ff <= nxt_oe;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_ff <= 8'h00;
      nack_ff <= 1'b0;
    end else begin
      if (scl_rise && st_ff == plc_pkg::ST_RXB)
        rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
      if (scl_rise && st_ff == plc_pkg::ST_MACK)
        nack_ff <= sda_s;
    end
  end

  // Frame bookkeeping: byte count, direction, read byte index
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_ff <= 3'h0;
      rd_ff <= 1'b0;
      tx_hi_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      byte_cnt_ff <= 3'h0;
      rd_ff <= 1'b0;
      tx_hi_ff <= 1'b0;
    end else begin
      if (byte_take && byte_cnt_ff != 3'h7)
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
      if (byte_take && byte_cnt_ff == 3'h0)
        rd_ff <= rx_sh_ff[0];
      if (scl_fall && st_ff == plc_pkg::ST_MACK && !nack_ff)
        tx_hi_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= 8'h00;
      d0_ff <= 8'h00;
      d1_ff <= 8'h00;
    end else if (byte_take && !rd_ff) begin
      if (byte_cnt_ff == 3'h1)
        cmd_ff <= rx_sh_ff;
      if (byte_cnt_ff == 3'h2)
        d0_ff <= rx_sh_ff;
      if (byte_cnt_ff == 3'h3)
        d1_ff <= rx_sh_ff;
    end
  end

  // --------------------------------------------------------
  // Command decode at stop of a write frame
  // --------------------------------------------------------
  wire commit = stop_det & ~rd_ff & (byte_cnt_ff >= 3'h2);
  wire is_send = (byte_cnt_ff == 3'h2);
  wire is_byte = (byte_cnt_ff == 3'h3);
  wire is_word = (byte_cnt_ff == 3'h4);
  wire [15:0] wd = {d1_ff, d0_ff};
  wire [7:0] wg = cfg_ff.wguard;
  wire c_run = (cmd_ff == `PLC_CMD_RUN);
  wire c_onoff = (cmd_ff == `PLC_CMD_ONOFF);
  wire c_clr = (cmd_ff == `PLC_CMD_CLR);
  wire c_wg = (cmd_ff == `PLC_CMD_WG);
  wire c_store = (cmd_ff == `PLC_CMD_STORE);
  wire c_rest = (cmd_ff == `PLC_CMD_RESTORE);
  wire c_ova = (cmd_ff == `PLC_CMD_OV_ALERT);
  wire c_oca = (cmd_ff == `PLC_CMD_OC_ALERT);
  wire c_ot = (cmd_ff == `PLC_CMD_OT_TRIP);
  wire c_unl = (cmd_ff == `PLC_CMD_UNLOCK);
  wire c_vset = (cmd_ff == `PLC_CMD_VSET);
  wire guard_ok = c_wg | c_clr | (wg == `PLC_WG_NONE) |
                  ((wg == `PLC_WG_CFG) & (c_run | c_onoff | c_vset)) |
                  ((wg == `PLC_WG_OPS) & c_run);

  wire ok_run = c_run & is_byte;
  wire ok_onoff = c_onoff & is_byte &
                  ((d0_ff == `PLC_ONOFF_NEG) | (d0_ff == `PLC_ONOFF_POS));
  wire ok_wg = c_wg & is_byte &
               ((d0_ff == `PLC_WG_ALL) | (d0_ff == `PLC_WG_OPS) |
                (d0_ff == `PLC_WG_CFG) | (d0_ff == `PLC_WG_NONE));
  wire ok_unl = c_unl & is_byte;
  // clear is a send byte with no data
  wire ok_clr = c_clr & is_send;
  wire ok_store = c_store & is_send & unlock_ff;
  // restore refused while the stage runs
  wire ok_rest = c_rest & is_send & ~run_s;
  // alert range and not above the trip
  wire ok_ova = c_ova & is_word & (wd >= `PLC_OVA_MIN) &
                (wd <= `PLC_OVA_MAX) & (wd <= cfg_ff.ov_trip);
  // current alert kept below its trip
  wire ok_oca = c_oca & is_word & (wd >= `PLC_OCA_MIN) &
                (wd <= `PLC_OCA_MAX) & (wd < cfg_ff.oc_trip);
  // temperature trip range and above warning
  wire ok_ot = c_ot & is_word & (wd >= `PLC_OT_MIN) &
               (wd <= `PLC_OT_MAX) & (wd > `PLC_OT_WARN);

  wire valid = ok_run | ok_onoff | ok_wg | ok_unl | ok_clr | ok_store |
               ok_rest | ok_ova | ok_oca | ok_ot;
  wire accept = commit & guard_ok & valid;
  wire cml_set = commit & ~(guard_ok & valid);
  wire clr_go = accept & ok_clr;
  wire store_go = accept & ok_store;
  wire rest_go = accept & ok_rest;

  // --------------------------------------------------------
  // Parameter RAM, flash copy and faults
  // --------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= plc_pkg::PLC_CFG_RST;
    end else if (rest_go) begin
      cfg_ff <= flash_ff;
    end else if (accept) begin
      if (ok_run)
        cfg_ff.run_ctl <= d0_ff;
      if (ok_onoff)
        cfg_ff.onoff_cfg <= d0_ff;
      if (ok_wg)
        cfg_ff.wguard <= d0_ff;
      if (ok_ova)
        cfg_ff.ov_alert <= wd;
      if (ok_oca)
        cfg_ff.oc_alert <= wd;
      if (ok_ot)
        cfg_ff.ot_trip <= wd;
    end
  end

  // flash copy excludes the unlock state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ff <= plc_pkg::PLC_CFG_RST;
      unlock_ff <= 1'b0;
    end else if (store_go) begin
      flash_ff <= cfg_ff;
      unlock_ff <= 1'b0;
    end else if (accept && ok_unl) begin
      unlock_ff <= (d0_ff != 8'h00);
    end
  end

  // clear loses to a new event in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      fault_ff <= '0;
    else
      fault_ff <= (clr_go ? '0 : fault_ff) | {cml_set, fault_evt};
  end

  assign sda_o = sda_o_ff;
  assign sda_oe = sda_oe_ff;
  assign cfg = cfg_ff;
  assign faults = fault_ff;

  // --------------------------------------------------------
  // Assertions
  // --------------------------------------------------------
  default clocking dck @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_lin_exp_fixed: assert property (
    plc_pkg::plc_lin_exp(cfg_ff.oc_alert) == `PLC_EXP_IOUT &&
    plc_pkg::plc_lin_exp(cfg_ff.ot_trip) == `PLC_EXP_TEMP)
    else $error("linear exponent field changed");
  a_word_stored: assert property (
    accept && (ok_ova || ok_oca || ok_ot) |=>
    $past(wd) == (cfg_ff.ov_alert & {16{$past(ok_ova)}} |
                  cfg_ff.oc_alert & {16{$past(ok_oca)}} |
                  cfg_ff.ot_trip & {16{$past(ok_ot)}}))
    else $error("written word not stored as sent");
  a_vin_exp_fixed: assert property (
    plc_pkg::plc_lin_exp(cfg_ff.vin_on) == `PLC_EXP_VIN &&
    plc_pkg::plc_lin_exp(cfg_ff.vin_off) == `PLC_EXP_VIN)
    else $error("input voltage exponent not minus three");
  a_clear_faults: assert property (
    clr_go && fault_evt == '0 |=> fault_ff == '0)
    else $error("faults survive clear");
  a_guard_blocks: assert property (
    commit && wg == `PLC_WG_ALL && !c_wg && !c_clr |=>
    $stable(cfg_ff) && fault_ff.cml)
    else $error("guarded write landed");
  a_store_locked: assert property (
    commit && c_store && !unlock_ff |=> $stable(flash_ff) && fault_ff.cml)
    else $error("store without unlock");
  a_store_copy: assert property (
    store_go |=> flash_ff == $past(cfg_ff) && !unlock_ff)
    else $error("store did not copy parameters");
  a_restore_run: assert property (
    commit && c_rest && run_s |=> $stable(cfg_ff) ##0 fault_ff.cml)
    else $error("restore accepted while running");
  a_ova_order: assert property (
    cfg_ff.ov_alert <= cfg_ff.ov_trip && cfg_ff.ov_alert >= `PLC_OVA_MIN)
    else $error("overvoltage alert out of order");
  a_ot_above: assert property (
    $signed(plc_pkg::plc_lin_man(cfg_ff.ot_trip)) >
    $signed(plc_pkg::plc_lin_man(`PLC_OT_WARN)))
    else $error("temperature trip not above warning");
  a_ovtrip_fixed: assert property (
    $stable(cfg_ff.ov_trip) && cfg_ff.ov_trip > cfg_ff.vout_set &&
    cfg_ff.ov_trip >= cfg_ff.ov_alert)
    else $error("overvoltage trip moved or too low");
  a_ro_reject: assert property (
    commit && (c_vset || cmd_ff == `PLC_CMD_OV_TRIP) |=>
    $stable(cfg_ff) && fault_ff.cml)
    else $error("read-only write not rejected");
  a_oc_order: assert property (
    cfg_ff.oc_alert < cfg_ff.oc_trip)
    else $error("current alert not below trip");
  c_store_done: cover property (store_go);
  c_restore_done: cover property (rest_go);
  c_clear_done: cover property (clr_go);
  c_word_read: cover property (st_ff == plc_pkg::ST_MACK && tx_hi_ff);
endmodule

// ==== bench/plc_host_bfm.sv ====
// plc_host_bfm: bus master model driving the board clock and data lines
// Assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
module plc_host_bfm (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ----------------------------------------------------------
  // Bit level, 80 ns per bit
  // ----------------------------------------------------------
  task automatic put_bit(input logic b);
    #10 sda_pull = ~b;
    #30 scl = 1'b1;
    #40 scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    #10 sda_pull = 1'b0;
    #30 scl = 1'b1;
    #20 b = sda;
    #20 scl = 1'b0;
  endtask

  task automatic start_cond();
    #10 sda_pull = 1'b0;
    #30 scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
  endtask

  task automatic stop_cond();
    #10 sda_pull = 1'b1;
    #30 scl = 1'b1;
    #20 sda_pull = 1'b0;
    #40;
  endtask

  // ----------------------------------------------------------
  // Byte and frame level
  // ----------------------------------------------------------
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask

  // word data goes low byte first, exponent in top bits
  task automatic write_frame(input logic [6:0] adr, input logic [7:0] cmd,
                             input int n, input logic [15:0] d,
                             output logic ok);
    logic a;
    ok = 1'b1;
    start_cond();
    put_byte({adr, 1'b0}, a);
    ok &= a;
    put_byte(cmd, a);
    ok &= a;
    if (n > 0) begin
      put_byte(d[7:0], a);
      ok &= a;
    end
    if (n > 1) begin
      put_byte(d[15:8], a);
      ok &= a;
    end
    stop_cond();
  endtask

  // read word assembled low byte then high byte
  task automatic read_frame(input logic [6:0] adr, input logic [7:0] cmd,
                            output logic [15:0] d, output logic ok);
    logic a;
    ok = 1'b1;
    start_cond();
    put_byte({adr, 1'b0}, a);
    ok &= a;
    put_byte(cmd, a);
    ok &= a;
    start_cond();
    put_byte({adr, 1'b1}, a);
    ok &= a;
    get_byte(1'b0, d[7:0]);
    get_byte(1'b1, d[15:8]);
    stop_cond();
  endtask
endmodule

// ==== bench/plc_testbench.sv ====
// plc_testbench: command set checks through bus frames from the host model
// Assumes plc_pkg compiled first and a 100 MHz system clock
`timescale 1ns/10ps
module testbench;
  logic mclk, rst_n, scl, sda_pull, sda, sda_o, sda_oe, stage_run, ok;
  plc_pkg::plc_evt_t fault_evt;
  plc_pkg::plc_cfg_t cfg;
  plc_pkg::plc_fault_t faults;
  int n_fail, samples_checked, cycles;
  logic [15:0] rd;

  // Wired-AND data line with pull-up
  assign sda = ~(sda_pull | (sda_oe & ~sda_o));

  plc_command_set DUT (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .stage_run(stage_run),
    .fault_evt(fault_evt), .cfg(cfg), .faults(faults));
  plc_host_bfm host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [15:0] lin(input logic [4:0] e,
                                      input logic [10:0] m);
    return {e, m};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
    host.write_frame(7'h2a, cmd, n, d, ok);
    check("wr ack", {15'h0, ok}, 16'h0001);
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic rdw(input logic [7:0] cmd, input logic [15:0] exp,
                     input string what);
    host.read_frame(7'h2a, cmd, rd, ok);
    check({what, " ack"}, {15'h0, ok}, 16'h0001);
    check(what, rd, exp);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    stage_run = 1'b0;
    fault_evt = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    rdw(8'h10, 16'h0080, "guard");
    rdw(8'h40, 16'hd800, "ov trip");
    rdw(8'h4f, lin(5'h1e, 11'h21c), "ot trip");
    rdw(8'h35, lin(5'h1d, 11'h13c), "vin on");
    rdw(8'h36, lin(5'h1d, 11'h130), "vin off");
    check("vin off exp", {11'h0, rd[15:11]}, 16'h001d);
    $display("test reset values done");

    wr(8'h42, 2, 16'hc800);
    check("alert guarded", cfg.ov_alert, 16'hd000);
    wr(8'h10, 1, 16'h0000);
    check("guard open", {8'h0, cfg.wguard}, 16'h0000);
    $display("test write guard done");

    rdw(8'h20, 16'h0014, "mode");
    rdw(8'h21, 16'hc333, "setpoint");
    rdw(8'h46, 16'he9e0, "oc trip");
    rdw(8'h11, 16'hffff, "write only");
    wr(8'h02, 1, 16'h001f);
    check("onoff pos", {8'h0, cfg.onoff_cfg}, 16'h001f);
    wr(8'h02, 1, 16'h001e);
    check("onoff bad", {8'h0, cfg.onoff_cfg}, 16'h001f);
    wr(8'h10, 1, 16'h0040);
    wr(8'h01, 1, 16'h0000);
    check("run ops", {8'h0, cfg.run_ctl}, 16'h0000);
    wr(8'h02, 1, 16'h001d);
    check("onoff ops", {8'h0, cfg.onoff_cfg}, 16'h001f);
    wr(8'h10, 1, 16'h0020);
    wr(8'h02, 1, 16'h001d);
    check("onoff cfg", {8'h0, cfg.onoff_cfg}, 16'h001d);
    wr(8'h01, 2, 16'h0080);
    check("run length", {8'h0, cfg.run_ctl}, 16'h0000);
    wr(8'h10, 1, 16'h0000);
    $display("test byte commands done");

    wr(8'h42, 2, 16'hc800);
    check("alert low end", cfg.ov_alert, 16'hc800);
    wr(8'h42, 2, 16'hd800);
    check("alert at trip", cfg.ov_alert, 16'hd800);
    wr(8'h42, 2, 16'hc7ff);
    check("alert below", cfg.ov_alert, 16'hd800);
    check("range fault", {15'h0, faults.cml}, 16'h0001);
    wr(8'h42, 2, 16'hd801);
    check("alert above trip", cfg.ov_alert, 16'hd800);
    wr(8'h40, 2, 16'hd000);
    check("trip read only", cfg.ov_trip, 16'hd800);
    $display("test overvoltage limits done");

    @(posedge mclk);
    #1 fault_evt = 4'hf;
    @(posedge mclk);
    #1 fault_evt = 4'h0;
    check("faults set", {11'h0, faults}, 16'h001f);
    wr(8'h03, 0, 16'h0000);
    check("faults cleared", {11'h0, faults}, 16'h0000);
    $display("test fault clear done");

    wr(8'h4f, 2, lin(5'h1e, 11'h190));
    check("ot at warn", cfg.ot_trip, 16'hf21c);
    wr(8'h4f, 2, lin(5'h1e, 11'h1f0));
    check("ot inside", cfg.ot_trip, 16'hf1f0);
    wr(8'h4f, 2, lin(5'h1e, 11'h220));
    check("ot above", cfg.ot_trip, 16'hf1f0);
    wr(8'h4a, 2, lin(5'h1d, 11'h190));
    rdw(8'h4a, 16'he990, "oc alert");
    wr(8'h4a, 2, lin(5'h1d, 11'h1e0));
    check("oc at trip", cfg.oc_alert, 16'he990);
    $display("test limit ordering done");

    // store while locked leaves the flash copy at defaults
    wr(8'h11, 0, 16'h0000);
    wr(8'h12, 0, 16'h0000);
    check("restore default", cfg.ov_alert, 16'hd000);
    check("restore ot", cfg.ot_trip, 16'hf21c);
    wr(8'h10, 1, 16'h0000);
    wr(8'h42, 2, 16'hc800);
    wr(8'hec, 1, 16'h0001);
    wr(8'h11, 0, 16'h0000);
    wr(8'h42, 2, 16'hcc00);
    check("before restore", cfg.ov_alert, 16'hcc00);
    wr(8'h12, 0, 16'h0000);
    check("restored", cfg.ov_alert, 16'hc800);
    // restore deliberately sent while the stage runs
    @(posedge mclk);
    #1 stage_run = 1'b1;
    wr(8'h42, 2, 16'hd000);
    wr(8'h12, 0, 16'h0000);
    check("restore refused", cfg.ov_alert, 16'hd000);
    @(posedge mclk);
    #1 stage_run = 1'b0;
    $display("test flash copy done");
    wrap_up();
  end
endmodule
